// File: shared/lvd_pkg.sv
// constants and types for the undervoltage detector control block
// assumes an 8-bit internal special-function-register bus with 16-bit addresses
package lvd_pkg;
    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [15:0] ADDR_CONTROL = 16'hffbe;
    localparam logic [15:0] ADDR_LEVEL = 16'hffbf;
    localparam logic [15:0] ADDR_PORT12_DIR = 16'hff2c;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] LEVEL_RESET = 8'h00;
    localparam logic [7:0] PORT12_DIR_RESET = 8'hff;
    localparam logic [7:0] PORT12_DIR_FIXED_ONES = 8'hf8;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int ENABLE_POS = 7;
    localparam int SOURCE_POS = 2;
    localparam int MODE_POS = 1;
    localparam int FLAG_POS = 0;
    localparam int THRESHOLD_POS = 0;
    localparam int SENSE_DIR_POS = 0;
    localparam int PORT12_DIR_BITS = 3;
    // ----------------------------------------
    // comparator selections
    // ----------------------------------------
    typedef enum logic [1:0] {
        cmp_supply_high_type_sel,
        cmp_supply_low_type_sel,
        cmp_external_type_sel
    } cmp_select_type;
endpackage

// File: shared/sync_if.sv
// carrier between the top module and its synchroniser
// assumes one clock domain, the system clock
`timescale 1ns/1ps
interface sync_if;
    logic async_level;
    logic sync_level;
    modport src (output async_level, input sync_level);
    modport dst (input async_level, output sync_level);
endinterface

// File: hw/level_sync.sv
// two-stage synchroniser for one asynchronous level
// assumes clk_i is the system clock and reset_i is asynchronous high
`timescale 1ns/1ps
module level_sync (
    input wire logic clk_i,
    input wire logic reset_i,
    sync_if.dst port
);
    logic stage1_reg;
    logic stage2_reg;
    // ----------------------------------------
    // two flip-flops
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= port.async_level;
            stage2_reg <= stage1_reg;
        end
    end
    assign port.sync_level = stage2_reg;
endmodule

// File: hw/low_voltage_detect_control.sv
// control logic of the undervoltage detector: registers, source and response selection
// assumes an analog comparator outside, an 8-bit register bus, and the chip reset tree
//
// Overview of operation
// - level-select register at ffbf, cleared by reset, byte or bit writable
// - bit 0 of level select picks high or low supply threshold
// - external source uses fixed reference and ignores level select
// - port-mode register at ff2c resets to ff, bits 7 to 3 read one
// - reset mode on supply holds reset request while supply is low
// - reset mode on pin holds reset request while pin is low
// - interrupt mode raises the request when selected source is low
// - control bit 2 selects supply when clear, external pin when set
// - no internal reset when voltage is good as reset mode starts
// - any reset sets the interrupt mask flag
// - a detector reset sets bit 0 of the reset-cause register
// - control register at ffbe: enable 7, source 2, mode 1, flag 0
// - enable, mode, source survive a detector reset, else cleared
// - flag drives interrupt request only when enabled and in interrupt mode
// - flag is one only when enabled and selected source is low
`timescale 1ns/1ps
module low_voltage_detect_control
    import lvd_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic detector_reset_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic bus_write_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic [7:0] bus_wmask_i,
    output logic [7:0] bus_rdata_o,
    input wire logic comparator_below_i,
    output logic [1:0] comparator_select_o,
    output logic comparator_enable_o,
    output logic [2:0] port12_direction_o,
    output logic undervoltage_irq_o,
    output logic internal_reset_request_o,
    output logic undervoltage_reset_cause_o,
    output logic undervoltage_irq_mask_o
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic enable_reg;
    logic source_reg;
    logic mode_reg;
    logic threshold_reg;
    logic [PORT12_DIR_BITS-1:0] port_dir_reg;
    logic cause_reg;
    logic mask_reg;
    logic below_sync;
    logic below;
    logic write_control;
    logic write_level;
    logic write_port;
    logic [7:0] control_merge;
    logic [7:0] level_merge;
    logic [7:0] port_merge;
    logic [7:0] control_view;
    logic [7:0] level_view;
    logic [7:0] port_view;
    cmp_select_type sel;
    sync_if cmp_sync ();

    assign cmp_sync.async_level = comparator_below_i;
    level_sync i_level_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .port(cmp_sync)
    );
    assign below_sync = cmp_sync.sync_level;

    // ----------------------------------------
    // register views and bit-wise write merge
    // ----------------------------------------
    assign control_view = {enable_reg, 4'h0, source_reg, mode_reg, below};
    assign level_view = {7'h00, threshold_reg};
    assign port_view = PORT12_DIR_FIXED_ONES | {5'h00, port_dir_reg};
    assign control_merge = (bus_wdata_i & bus_wmask_i) | (control_view & ~bus_wmask_i);
    assign level_merge = (bus_wdata_i & bus_wmask_i) | (level_view & ~bus_wmask_i);
    assign port_merge = (bus_wdata_i & bus_wmask_i) | (port_view & ~bus_wmask_i);
    assign write_control = bus_write_i && (bus_addr_i == ADDR_CONTROL);
    assign write_level = bus_write_i && (bus_addr_i == ADDR_LEVEL);
    assign write_port = bus_write_i && (bus_addr_i == ADDR_PORT12_DIR);

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            enable_reg <= CONTROL_RESET[ENABLE_POS];
            source_reg <= CONTROL_RESET[SOURCE_POS];
            mode_reg <= CONTROL_RESET[MODE_POS];
        end else if (detector_reset_i) begin
            enable_reg <= enable_reg;
            source_reg <= source_reg;
            mode_reg <= mode_reg;
        end else if (write_control) begin
            enable_reg <= control_merge[ENABLE_POS];
            source_reg <= control_merge[SOURCE_POS];
            mode_reg <= control_merge[MODE_POS];
        end
    end

    // ----------------------------------------
    // level select and port mode
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            threshold_reg <= LEVEL_RESET[THRESHOLD_POS];
        end else if (detector_reset_i) begin
            threshold_reg <= LEVEL_RESET[THRESHOLD_POS];
        end else if (write_level) begin
            threshold_reg <= level_merge[THRESHOLD_POS];
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            port_dir_reg <= PORT12_DIR_RESET[PORT12_DIR_BITS-1:0];
        end else if (detector_reset_i) begin
            port_dir_reg <= PORT12_DIR_RESET[PORT12_DIR_BITS-1:0];
        end else if (write_port) begin
            port_dir_reg <= port_merge[PORT12_DIR_BITS-1:0];
        end
    end

    // ----------------------------------------
    // interrupt mask and reset cause
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mask_reg <= 1'b1;
            cause_reg <= 1'b0;
        end else if (detector_reset_i) begin
            mask_reg <= 1'b1;
            cause_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // comparator selection and responses
    // ----------------------------------------
    always_comb begin
        if (source_reg) begin
            sel = cmp_external_type_sel;
        end else if (threshold_reg) begin
            sel = cmp_supply_low_type_sel;
        end else begin
            sel = cmp_supply_high_type_sel;
        end
    end

    assign below = enable_reg & below_sync;
    assign comparator_select_o = sel;
    assign comparator_enable_o = enable_reg;
    assign port12_direction_o = port_dir_reg;
    assign undervoltage_irq_o = below & ~mode_reg;
    assign internal_reset_request_o = below & mode_reg;
    assign undervoltage_reset_cause_o = cause_reg;
    assign undervoltage_irq_mask_o = mask_reg;

    always_comb begin
        case (bus_addr_i)
            ADDR_CONTROL: bus_rdata_o = control_view;
            ADDR_LEVEL: bus_rdata_o = level_view;
            ADDR_PORT12_DIR: bus_rdata_o = port_view;
            default: bus_rdata_o = 8'h00;
        endcase
    end
endmodule

// File: tb/lvd_cmp_model.sv
// comparator model: millivolt levels in, below flag out
// assumes the select and enable outputs of the control block
`timescale 1ns/1ps
module lvd_cmp_model
    import lvd_pkg::*;
#(
    parameter int HIGH_MV = 4240,
    parameter int LOW_MV = 4090,
    parameter int EXT_MV = 1210
) (
    input wire logic [1:0] sel_i,
    input wire logic en_i,
    input wire logic [15:0] supply_mv_i,
    input wire logic [15:0] pin_mv_i,
    output logic below_o
);
    // not held low while off: the block has to mask it
    always_comb begin
        if (!en_i) below_o = 1'b1;
        else if (sel_i == cmp_external_type_sel) below_o = pin_mv_i < EXT_MV;
        else if (sel_i == cmp_supply_low_type_sel) below_o = supply_mv_i < LOW_MV;
        else below_o = supply_mv_i < HIGH_MV;
    end
endmodule

// File: tb/lvd_properties.sv
// port assertions of the undervoltage detector control block
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
module lvd_checker
    import lvd_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic detector_reset_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic bus_write_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic [7:0] bus_wmask_i,
    input wire logic [7:0] bus_rdata_o,
    input wire logic comparator_below_i,
    input wire logic comparator_enable_o,
    input wire logic [2:0] port12_direction_o,
    input wire logic undervoltage_irq_o,
    input wire logic internal_reset_request_o,
    input wire logic undervoltage_reset_cause_o,
    input wire logic undervoltage_irq_mask_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    wire logic ctl = bus_addr_i == ADDR_CONTROL;
    wire logic irq = undervoltage_irq_o;
    wire logic rq = internal_reset_request_o;
    sequence s_en_wr;
        bus_write_i && ctl && bus_wmask_i[ENABLE_POS] && !detector_reset_i;
    endsequence
    property p_wr; s_en_wr |=> comparator_enable_o == $past(bus_wdata_i[ENABLE_POS]); endproperty
    a_wr: assert property (p_wr) else $error("enable write");
    property p_out; ctl |-> irq == (bus_rdata_o[0] && !bus_rdata_o[1]); endproperty
    a_out: assert property (p_out) else $error("irq vs flag");
    property p_rq; ctl |-> rq == (bus_rdata_o[0] && bus_rdata_o[1]); endproperty
    a_rq: assert property (p_rq) else $error("reset vs flag");
    property p_sync; (irq || rq) |-> $past(comparator_below_i, 2); endproperty
    a_sync: assert property (p_sync) else $error("sync delay");
    property p_off; !comparator_enable_o |-> !irq && !rq; endproperty
    a_off: assert property (p_off) else $error("output while off");
    property p_port; bus_addr_i == ADDR_PORT12_DIR |-> bus_rdata_o[7:3] == 5'h1f; endproperty
    a_port: assert property (p_port) else $error("port12 fixed bits");
    property p_keep; detector_reset_i |=> $stable(comparator_enable_o); endproperty
    a_keep: assert property (p_keep) else $error("enable lost");
    property p_cause; detector_reset_i |=> undervoltage_reset_cause_o; endproperty
    a_cause: assert property (p_cause) else $error("cause not set");
endmodule
bind low_voltage_detect_control lvd_checker i_lvd_checker (.*);

// File: tb/low_voltage_detect_control_tb_top.sv
// bench for the undervoltage detector control block
// assumes the comparator model on the analog side
`timescale 1ns/1ps
module low_voltage_detect_control_tb_top;
    import lvd_pkg::*;
    logic clk_i = 0, reset_i = 1, drst = 0, we = 0, below, en, irq, rq, cause, mask;
    logic [15:0] addr = 0, sup = 16'd5000, pin = 16'd2000;
    logic [7:0] wd = 0, wm = 0, rdata;
    logic [1:0] sel;
    logic [2:0] dir;
    int err_total = 0, tests_run = 0;
    always #2 clk_i = ~clk_i;
    low_voltage_detect_control i_low_voltage_detect_control (.clk_i(clk_i), .reset_i(reset_i),
        .detector_reset_i(drst), .bus_addr_i(addr), .bus_write_i(we), .bus_wdata_i(wd),
        .bus_wmask_i(wm), .bus_rdata_o(rdata), .comparator_below_i(below),
        .comparator_select_o(sel), .comparator_enable_o(en), .port12_direction_o(dir),
        .undervoltage_irq_o(irq), .internal_reset_request_o(rq),
        .undervoltage_reset_cause_o(cause), .undervoltage_irq_mask_o(mask));
    lvd_cmp_model i_lvd_cmp_model (.sel_i(sel), .en_i(en), .supply_mv_i(sup), .pin_mv_i(pin),
        .below_o(below));
    task ck(input string n, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
        @(negedge clk_i);
        addr = a;
        wd = d;
        wm = m;
        we = 1;
        @(negedge clk_i);
        we = 0;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        addr = a;
        #1 ck("rdata", e, rdata);
    endtask
    task io(input logic [1:0] e);
        ck("irq_req", {6'h0, e}, {6'h0, irq, rq});
    endtask
    task w3;
        repeat (3) @(negedge clk_i);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        err_total++;
        print_verdict;
    end
    initial begin
        repeat (10) @(negedge clk_i);
        reset_i = 0;
        rd(ADDR_CONTROL, CONTROL_RESET);
        rd(ADDR_PORT12_DIR, PORT12_DIR_RESET);
        ck("dir", 8'h07, {5'h00, dir});
        ck("mask", 8'h01, {7'h0, mask});
        rd(16'h1234, 8'h00);
        wr(ADDR_LEVEL, 8'h01, 8'hff);
        rd(ADDR_LEVEL, 8'h01);
        wr(ADDR_PORT12_DIR, 8'h00, 8'hff);
        rd(ADDR_PORT12_DIR, 8'hf8);
        ck("dir", 8'h00, {5'h00, dir});
        wr(ADDR_PORT12_DIR, 8'hff, 8'h01);
        rd(ADDR_PORT12_DIR, 8'hf9);
        ck("dir", 8'h01, {5'h00, dir});
        sup = 16'd4100;
        ck("mask", 8'h01, {7'h0, mask});
        wr(ADDR_CONTROL, 8'h80, 8'hff);
        w3;
        rd(ADDR_CONTROL, 8'h80);
        ck("sel", 8'h01, {6'h00, sel});
        wr(ADDR_CONTROL, 8'h00, 8'hff);
        wr(ADDR_LEVEL, 8'h00, 8'hff);
        wr(ADDR_CONTROL, 8'h80, 8'hff);
        w3;
        rd(ADDR_CONTROL, 8'h81);
        ck("sel", 8'h00, {6'h00, sel});
        io(2'b10);
        wr(ADDR_CONTROL, 8'h00, 8'h80);
        rd(ADDR_CONTROL, 8'h00);
        io(2'b00);
        sup = 16'd5000;
        wr(ADDR_CONTROL, 8'h80, 8'h80);
        w3;
        rd(ADDR_CONTROL, 8'h80);
        wr(ADDR_CONTROL, 8'h82, 8'h02);
        w3;
        io(2'b00);
        sup = 16'd4000;
        w3;
        io(2'b01);
        wr(ADDR_CONTROL, 8'h00, 8'hff);
        pin = 16'd1300;
        wr(ADDR_CONTROL, 8'h04, 8'hff);
        wr(ADDR_CONTROL, 8'h84, 8'h80);
        w3;
        rd(ADDR_CONTROL, 8'h84);
        ck("sel", 8'h02, {6'h00, sel});
        io(2'b00);
        pin = 16'd1000;
        w3;
        rd(ADDR_CONTROL, 8'h85);
        io(2'b10);
        pin = 16'd1300;
        w3;
        rd(ADDR_CONTROL, 8'h84);
        wr(ADDR_CONTROL, 8'h86, 8'h02);
        pin = 16'd1000;
        w3;
        io(2'b01);
        drst = 1;
        @(negedge clk_i);
        drst = 0;
        rd(ADDR_CONTROL, 8'h87);
        rd(ADDR_PORT12_DIR, PORT12_DIR_RESET);
        ck("cause", 8'h01, {7'h0, cause});
        wr(ADDR_CONTROL, 8'hff, 8'hff);
        rd(ADDR_CONTROL, 8'h87);
        wr(ADDR_CONTROL, 8'h00, 8'h02);
        io(2'b10);
        wr(ADDR_CONTROL, 8'h00, 8'h80);
        io(2'b00);
        reset_i = 1;
        @(negedge clk_i);
        reset_i = 0;
        rd(ADDR_CONTROL, CONTROL_RESET);
        ck("cause", 8'h00, {7'h0, cause});
        print_verdict;
    end
endmodule
